// file: src/ptu_pkg.sv
package ptu_pkg;

	// Channel set and the channels that own general registers C and D.
	localparam int NUM_CH = 6;
	localparam int PINS_PER_CH = 4;
	localparam logic [5:0] WIDE_CH_MASK = 6'h09;

	// Word indices on the register bus; byte address is four times the index.
	localparam int ADDR_W = 5;
	localparam int CH_STRIDE = 4;
	localparam logic [4:0] IDX_CLK_CTRL = 5'h00;
	localparam logic [4:0] IDX_MODE_CTRL = 5'h01;
	localparam logic [4:0] IDX_PIN_HIGH = 5'h02;
	localparam logic [4:0] IDX_PIN_LOW = 5'h03;
	localparam logic [4:0] IDX_CH_LIMIT = 5'h18;
	localparam logic [4:0] IDX_START = 5'h18;
	localparam logic [4:0] IDX_SYNC = 5'h19;
	localparam logic [4:0] IDX_PIN_STATUS = 5'h1a;

	// Reset values.
	localparam logic [7:0] CLK_CTRL_RST = 8'h00;
	localparam logic [5:0] MODE_CTRL_RST = 6'h00;
	localparam logic [7:0] PIN_CTRL_RST = 8'h00;
	localparam logic [5:0] START_RST = 6'h00;
	localparam logic [5:0] SYNC_RST = 6'h00;
	localparam logic [1:0] MODE_FIXED_ONES = 2'h3;

	// Field positions in the clock control register.
	localparam int CLR_HI = 7;
	localparam int CLR_LO = 5;
	localparam int EDGE_HI = 4;
	localparam int EDGE_LO = 3;
	localparam int PSC_HI = 2;
	localparam int PSC_LO = 0;

	// Field positions in the mode control register.
	localparam int BUF_B_BIT = 5;
	localparam int BUF_A_BIT = 4;
	localparam int OPM_HI = 3;
	localparam int OPM_LO = 0;

	// Clear source codes.
	localparam logic [2:0] CLR_REG_A = 3'h1;
	localparam logic [2:0] CLR_REG_B = 3'h2;
	localparam logic [2:0] CLR_REG_C = 3'h5;
	localparam logic [2:0] CLR_REG_D = 3'h6;
	localparam logic [1:0] CLR_SYNC_LOW = 2'h3;

	// Prescaler taps: bit k of the free divider toggles with period 2^(k+1).
	localparam int DIV_W = 12;
	localparam int TAP_DIV4 = 1;
	localparam int TAP_DIV16 = 3;
	localparam int TAP_DIV64 = 5;
	localparam int TAP_DIV256 = 7;
	localparam int TAP_DIV1024 = 9;
	localparam int TAP_DIV4096 = 11;

	// Operating mode of a channel.
	typedef enum logic [2:0] {
		PTU_NORMAL = 3'b000,
		PTU_PWM1 = 3'b001,
		PTU_PWM2 = 3'b010,
		PTU_PHASE1 = 3'b011,
		PTU_PHASE2 = 3'b100,
		PTU_PHASE3 = 3'b101,
		PTU_PHASE4 = 3'b110,
		PTU_PROHIBITED = 3'b111
	} ptu_mode_t;

endpackage

// file: src/ptu_counter_config.sv
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

// Function
// [R01] Wide channels decode 3-bit clear source: off, A, B, C, D or sync clear.
// [R02] Sync clear follows another synced channel's own clear when selected and sync set.
// [R03] Register C or D held as buffer never clears the counter.
// [R04] Narrow channels keep clear bit 7 at zero; two bits select off, A, B, sync.
// [R05] Edge code: internal falling/external rising, reversed, or both edges.
// [R06] Channel 0 sources: clock /1, /4, /16, /64, pins A to D.
// [R07] Channel 1 adds pins A, B, /256 and channel 2 wrap; not in phase mode.
// [R08] Channel 2 adds pins A, B, C and /1024; not in phase mode.
// [R09] Channel 3 adds pin A, /1024, /256 and /4096.
// [R10] Channel 4 adds pins A, C, /1024 and channel 5 wrap; not in phase mode.
// [R11] Channel 5 adds pins A, C, /256 and pin D; not in phase mode.
// [R12] Top two mode bits read one and ignore writes.
// [R13] Buffer bit B pairs B with D and silences D's events; narrow reads zero.
// [R14] Buffer bit A pairs A with C and silences C's events; narrow reads zero.
// [R15] Mode field: normal, PWM 1, PWM 2, phase 1 to 4, others prohibited.
// [R16] Software writes zero to mode bit 3, and bit 2 on channels 0 and 3.
// [R17] Software changes mode and pin settings only while the counter is stopped.
// [R18] Stopped counter drives initial pin level; PWM 2 reloads it on counter clear.
// [R19] Buffered register C or D ignores its pin control setting.
// [R20] Eight pin control registers; high nibble controls B or D, low A or C.
// [R21] Edge code ignored for undivided clock and for cascade wrap sources.
// [R22] Compare code drives initial level then 0, 1 or toggle; x000 and x100 off.
// [R23] New count and clear sources take effect only from the next restart.
module ptu_counter_config (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// Avalon-MM register slave.
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// External clock pins.
	input wire logic ext_clock_pin_a,
	input wire logic ext_clock_pin_b,
	input wire logic ext_clock_pin_c,
	input wire logic ext_clock_pin_d,
	// Events from the counting datapath, one bit per channel.
	input wire logic [5:0] match_a,
	input wire logic [5:0] match_b,
	input wire logic [5:0] match_c,
	input wire logic [5:0] match_d,
	input wire logic [5:0] counter_wrap,
	// Counter control towards the datapath, one bit per channel, three for the mode state.
	output logic [5:0] count_tick,
	output logic [5:0] count_clear,
	output logic [5:0] counter_run_bit,
	output logic [17:0] op_mode_state,
	// Compare output pins, four per channel, index channel*4 + register.
	output logic [23:0] cmp_pin_out,
	output logic [23:0] cmp_pin_oe
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic ack_q, wr_ok;
	logic [31:0] rd_d, rd_q;
	logic [5:0] start_q, sync_q;
	logic [11:0] div_q, div_rise, div_fall;
	logic [3:0] ext_pin, ext_prev_q, ext_rise, ext_fall;
	logic [5:0] own_clr, clr_d, sync_sel, tick_q, clear_q;
	logic [5:0][7:0] clk_ctrl_v, mode_v, pin_hi_v, pin_lo_v;
	logic [5:0][2:0] mode_state_v;
	logic [23:0] pin_out_q, pin_oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Internal clock edge choice; bit 1 set counts both edges.
	function automatic logic int_edge(input logic r, input logic f, input logic [1:0] e);
		int_edge = e[1] ? (r | f) : (e[0] ? r : f); // [R05]
	endfunction

	// External pin edge choice, opposite sense to the internal one.
	function automatic logic ext_edge(input logic r, input logic f, input logic [1:0] e);
		ext_edge = e[1] ? (r | f) : (e[0] ? f : r); // [R05]
	endfunction

	// Count source per channel and prescale code.
	function automatic logic src_tick(
		input int ch,
		input logic [2:0] psc,
		input logic [1:0] e,
		input logic [11:0] dr,
		input logic [11:0] df,
		input logic [3:0] xr,
		input logic [3:0] xf,
		input logic [5:0] wrap
	);
		logic t;
		logic [1:0] k1, k256, k4;
		t = 1'b0;
		// Slow taps as rise and fall pairs, shared by several codes.
		k1 = {dr[ptu_pkg::TAP_DIV1024], df[ptu_pkg::TAP_DIV1024]};
		k256 = {dr[ptu_pkg::TAP_DIV256], df[ptu_pkg::TAP_DIV256]};
		k4 = {dr[ptu_pkg::TAP_DIV4096], df[ptu_pkg::TAP_DIV4096]};
		unique case (psc)
			3'h0: t = 1'b1; // [R21]
			3'h1: t = int_edge(dr[ptu_pkg::TAP_DIV4], df[ptu_pkg::TAP_DIV4], e); // [R06]
			3'h2: t = int_edge(dr[ptu_pkg::TAP_DIV16], df[ptu_pkg::TAP_DIV16], e);
			3'h3: t = int_edge(dr[ptu_pkg::TAP_DIV64], df[ptu_pkg::TAP_DIV64], e);
			3'h4: t = ext_edge(xr[0], xf[0], e);
			3'h5: t = (ch == 3) ? int_edge(k1[1], k1[0], e) : // [R09]
				ext_edge(xr[ch >= 4 ? 2 : 1], xf[ch >= 4 ? 2 : 1], e); // [R10] [R11]
			3'h6: t = (ch == 0 || ch == 2) ? ext_edge(xr[2], xf[2], e) : // [R06] [R08]
				(ch == 4) ? int_edge(k1[1], k1[0], e) : // [R10]
				int_edge(k256[1], k256[0], e); // [R07] [R09] [R11]
			3'h7: t = (ch == 1) ? wrap[2] : (ch == 4) ? wrap[5] : // [R07] [R10] [R21]
				(ch == 2) ? int_edge(k1[1], k1[0], e) : // [R08]
				(ch == 3) ? int_edge(k4[1], k4[0], e) : // [R09]
				ext_edge(xr[3], xf[3], e); // [R06] [R11]
		endcase
		src_tick = t;
	endfunction

	// Mode field decode; bit 3 set or code 0001 is prohibited.
	function automatic ptu_pkg::ptu_mode_t decode_mode(input logic [3:0] m);
		ptu_pkg::ptu_mode_t s;
		s = ptu_pkg::PTU_PROHIBITED;
		unique case (m)
			4'h0: s = ptu_pkg::PTU_NORMAL; // [R15]
			4'h2: s = ptu_pkg::PTU_PWM1;
			4'h3: s = ptu_pkg::PTU_PWM2;
			4'h4: s = ptu_pkg::PTU_PHASE1;
			4'h5: s = ptu_pkg::PTU_PHASE2;
			4'h6: s = ptu_pkg::PTU_PHASE3;
			4'h7: s = ptu_pkg::PTU_PHASE4;
			default: s = ptu_pkg::PTU_PROHIBITED;
		endcase
		decode_mode = s;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	// One wait cycle per access; the access completes when waitrequest is low.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_ok = avs_write & ack_q & avs_byteenable[0];

	// Read data is captured in the wait cycle so it stands when the access ends.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= 32'h0000_0000;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign avs_readdata = rd_q;

	// Read multiplexer; unmapped words read zero.
	always_comb begin
		rd_d = 32'h0000_0000;
		if (avs_address < ptu_pkg::IDX_CH_LIMIT) begin
			unique case (avs_address[1:0])
				ptu_pkg::IDX_CLK_CTRL[1:0]: rd_d[7:0] = clk_ctrl_v[avs_address[4:2]];
				ptu_pkg::IDX_MODE_CTRL[1:0]: rd_d[7:0] = mode_v[avs_address[4:2]];
				ptu_pkg::IDX_PIN_HIGH[1:0]: rd_d[7:0] = pin_hi_v[avs_address[4:2]];
				ptu_pkg::IDX_PIN_LOW[1:0]: rd_d[7:0] = pin_lo_v[avs_address[4:2]];
			endcase
		end else if (avs_address == ptu_pkg::IDX_START) begin
			rd_d[5:0] = start_q;
		end else if (avs_address == ptu_pkg::IDX_SYNC) begin
			rd_d[5:0] = sync_q;
		end else if (avs_address == ptu_pkg::IDX_PIN_STATUS) begin
			rd_d[23:0] = pin_out_q;
		end
	end

	// Common start and sync registers.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			start_q <= ptu_pkg::START_RST;
			sync_q <= ptu_pkg::SYNC_RST;
		end else begin
			if (wr_ok && avs_address == ptu_pkg::IDX_START) begin
				start_q <= avs_writedata[5:0];
			end
			if (wr_ok && avs_address == ptu_pkg::IDX_SYNC) begin
				sync_q <= avs_writedata[5:0];
			end
		end
	end

	assign counter_run_bit = start_q;

	////////////////////////////////////////////////////////////////////////////
	// Shared prescaler and external pin edge detection.

	// Free-running divider; a tap's edge is flagged in the cycle before it flips.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 12'h000;
			ext_prev_q <= 4'h0;
		end else begin
			div_q <= div_q + 12'h001;
			ext_prev_q <= ext_pin;
		end
	end

	assign ext_pin = {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_b, ext_clock_pin_a};
	assign ext_rise = ext_pin & ~ext_prev_q;
	assign ext_fall = ~ext_pin & ext_prev_q;

	// Edge flags for each divider bit.
	for (genvar k = 0; k < ptu_pkg::DIV_W; k++) begin : g_tap
		localparam logic [11:0] LOW_MASK = 12'((1 << k) - 1);
		assign div_rise[k] = ((div_q & LOW_MASK) == LOW_MASK) & ~div_q[k];
		assign div_fall[k] = ((div_q & LOW_MASK) == LOW_MASK) & div_q[k];
	end

	////////////////////////////////////////////////////////////////////////////
	// Synchronous clear across channels.

	// A running synced channel set to sync clear follows any other synced channel's own clear.
	always_comb begin
		clr_d = own_clr;
		for (int c = 0; c < ptu_pkg::NUM_CH; c++) begin
			if (sync_sel[c] && sync_q[c] && start_q[c] &&
					|(own_clr & sync_q & ~(6'h01 << c))) begin
				clr_d[c] = 1'b1; // [R02]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel registers, count source and clear source.
	for (genvar ch = 0; ch < ptu_pkg::NUM_CH; ch++) begin : g_ch
		localparam logic WIDE = ptu_pkg::WIDE_CH_MASK[ch];
		logic [7:0] clk_ctrl_q, pin_hi_q, pin_lo_q, act_clk_q;
		logic [5:0] mode_q, act_mode_q;
		ptu_pkg::ptu_mode_t mode_state_q;
		logic phase;
		logic [2:0] clr_code;
		logic wr_here;

		assign wr_here = wr_ok && avs_address < ptu_pkg::IDX_CH_LIMIT &&
			avs_address[4:2] == 3'(ch);

		// Software-visible channel registers; reserved bits never store.
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				clk_ctrl_q <= ptu_pkg::CLK_CTRL_RST;
				mode_q <= ptu_pkg::MODE_CTRL_RST;
				pin_hi_q <= ptu_pkg::PIN_CTRL_RST;
				pin_lo_q <= ptu_pkg::PIN_CTRL_RST;
			end else if (wr_here) begin
				unique case (avs_address[1:0])
					ptu_pkg::IDX_CLK_CTRL[1:0]: begin
						clk_ctrl_q <= avs_writedata[7:0];
						clk_ctrl_q[ptu_pkg::CLR_HI] <= WIDE & avs_writedata[ptu_pkg::CLR_HI]; // [R04]
					end
					ptu_pkg::IDX_MODE_CTRL[1:0]: begin
						mode_q[ptu_pkg::OPM_HI:ptu_pkg::OPM_LO] <= avs_writedata[3:0];
						mode_q[ptu_pkg::BUF_B_BIT] <= WIDE & avs_writedata[ptu_pkg::BUF_B_BIT]; // [R13]
						mode_q[ptu_pkg::BUF_A_BIT] <= WIDE & avs_writedata[ptu_pkg::BUF_A_BIT]; // [R14]
					end
					ptu_pkg::IDX_PIN_HIGH[1:0]: pin_hi_q <= avs_writedata[7:0]; // [R20]
					ptu_pkg::IDX_PIN_LOW[1:0]: begin
						if (WIDE) begin
							pin_lo_q <= avs_writedata[7:0]; // [R20]
						end
					end
				endcase
			end
		end

		// Top mode bits always read as one.
		assign mode_v[ch] = {ptu_pkg::MODE_FIXED_ONES, mode_q}; // [R12]
		assign clk_ctrl_v[ch] = clk_ctrl_q;
		assign pin_hi_v[ch] = pin_hi_q;
		assign pin_lo_v[ch] = pin_lo_q;

		// Working copies follow the registers only while the counter is stopped.
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				act_clk_q <= ptu_pkg::CLK_CTRL_RST;
				act_mode_q <= ptu_pkg::MODE_CTRL_RST;
			end else if (!start_q[ch]) begin
				act_clk_q <= clk_ctrl_q; // [R23]
				act_mode_q <= mode_q;
			end
		end

		// Registered mode decode.
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				mode_state_q <= ptu_pkg::PTU_NORMAL;
			end else begin
				mode_state_q <= decode_mode(act_mode_q[ptu_pkg::OPM_HI:ptu_pkg::OPM_LO]); // [R15]
			end
		end

		assign mode_state_v[ch] = mode_state_q;
		assign phase = !WIDE && act_mode_q[2] && !act_mode_q[3];
		assign clr_code = act_clk_q[ptu_pkg::CLR_HI:ptu_pkg::CLR_LO];
		assign sync_sel[ch] = clr_code[1:0] == ptu_pkg::CLR_SYNC_LOW; // [R02] [R23]

		// Own clear: compare match or capture of the chosen register.
		always_comb begin
			own_clr[ch] = 1'b0;
			if (start_q[ch]) begin
				unique case (clr_code)
					ptu_pkg::CLR_REG_A: own_clr[ch] = match_a[ch]; // [R01] [R04]
					ptu_pkg::CLR_REG_B: own_clr[ch] = match_b[ch];
					ptu_pkg::CLR_REG_C: own_clr[ch] = match_c[ch] & ~act_mode_q[ptu_pkg::BUF_A_BIT]; // [R03]
					ptu_pkg::CLR_REG_D: own_clr[ch] = match_d[ch] & ~act_mode_q[ptu_pkg::BUF_B_BIT]; // [R03]
					default: own_clr[ch] = 1'b0;
				endcase
			end
		end

		// Count and clear pulses; in phase mode no count source ticks channels 1, 2, 4 or 5.
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				tick_q[ch] <= 1'b0;
				clear_q[ch] <= 1'b0;
			end else begin
				tick_q[ch] <= start_q[ch] && !phase && src_tick(ch,
					act_clk_q[ptu_pkg::PSC_HI:ptu_pkg::PSC_LO],
					act_clk_q[ptu_pkg::EDGE_HI:ptu_pkg::EDGE_LO],
					div_rise, div_fall, ext_rise, ext_fall, counter_wrap); // [R07] [R08] [R10] [R11]
				clear_q[ch] <= clr_d[ch]; // [R01] [R02]
			end
		end

		////////////////////////////////////////////////////////////////////////
		// Compare output pins of this channel.
		for (genvar k = 0; k < ptu_pkg::PINS_PER_CH; k++) begin : g_pin
			localparam int IDX = ch * ptu_pkg::PINS_PER_CH + k;
			logic [3:0] ctl;
			logic exists;
			logic buffered;
			logic out_func;
			logic hit;

			assign ctl = (k == 0) ? pin_hi_q[3:0] : (k == 1) ? pin_hi_q[7:4] :
				(k == 2) ? pin_lo_q[3:0] : pin_lo_q[7:4]; // [R20]
			assign exists = (k < 2) || WIDE;
			assign buffered = (k == 2 && mode_q[ptu_pkg::BUF_A_BIT]) ||
				(k == 3 && mode_q[ptu_pkg::BUF_B_BIT]); // [R19]
			assign out_func = exists && !buffered && !ctl[3] && ctl[1:0] != 2'h0; // [R22]
			assign hit = (k == 0) ? match_a[ch] : (k == 1) ? match_b[ch] :
				(k == 2) ? match_c[ch] : match_d[ch];

			// Initial level while stopped, then the chosen action on each match.
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					pin_out_q[IDX] <= 1'b0;
					pin_oe_q[IDX] <= 1'b0;
				end else if (!out_func) begin
					pin_out_q[IDX] <= 1'b0;
					pin_oe_q[IDX] <= 1'b0;
				end else begin
					pin_oe_q[IDX] <= 1'b1;
					if (!start_q[ch]) begin
						pin_out_q[IDX] <= ctl[2]; // [R18]
					end else if (mode_state_q == ptu_pkg::PTU_PWM2 && clr_d[ch]) begin
						pin_out_q[IDX] <= ctl[2]; // [R18]
					end else if (hit) begin
						unique case (ctl[1:0])
							2'h1: pin_out_q[IDX] <= 1'b0; // [R22]
							2'h2: pin_out_q[IDX] <= 1'b1;
							2'h3: pin_out_q[IDX] <= ~pin_out_q[IDX];
							default: pin_out_q[IDX] <= pin_out_q[IDX];
						endcase
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output assignments.
	assign count_tick = tick_q;
	assign count_clear = clear_q;
	assign op_mode_state = mode_state_v;
	assign cmp_pin_out = pin_out_q;
	assign cmp_pin_oe = pin_oe_q;

endmodule

// file: tb/ptu_chk_sva.sv
`timescale 1ns/1ps

// Watches the register bus and the channel 0 count controls at the top ports.
module ptu_chk (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register bus.
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Datapath side.
	input wire logic [5:0] match_a,
	input wire logic [5:0] count_tick,
	input wire logic [5:0] count_clear,
	input wire logic [5:0] counter_run_bit
);
	logic [7:0] clk0_q;
	logic rd_ok;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Shadow of the channel 0 clock control, which software changes only while stopped.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk0_q <= 8'h00;
		end else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 5'h00) begin
			clk0_q <= avs_writedata[7:0];
		end
	end

	// A read is completed at the edge where waitrequest is low.
	assign rd_ok = avs_read && !avs_waitrequest;

	////////////////////////////////////////////////////////////////////////////////
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first cycle of an access");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	a_idle_tick: assert property ((counter_run_bit == 6'h00) [*2] |-> count_tick == 6'h00)
		else $error("tick while every counter is stopped");
	a_idle_clear: assert property (!counter_run_bit[0] && !$past(counter_run_bit[0])
		|-> !count_clear[0])
		else $error("clear while channel 0 is stopped");
	a_tick_div1: assert property (counter_run_bit[0] && $past(counter_run_bit[0])
		&& clk0_q[2:0] == 3'h0 |-> count_tick[0])
		else $error("undivided clock does not tick every cycle");
	a_clear_src_a: assert property (counter_run_bit[0] && clk0_q[7:5] == 3'h1 && match_a[0]
		|=> count_clear[0])
		else $error("register A event did not clear channel 0");
	a_mode_ones: assert property (rd_ok && avs_address[1:0] == 2'h1 && avs_address < 5'h18
		|-> avs_readdata[7:6] == 2'h3)
		else $error("mode register top bits not read as one");
	a_narrow_rsvd: assert property (rd_ok && avs_address == 5'h05
		|-> avs_readdata[5:4] == 2'h0 && avs_readdata[31:8] == 24'h0)
		else $error("buffer bits of a narrow channel not zero");
	a_narrow_clr: assert property (rd_ok && avs_address == 5'h04 |-> !avs_readdata[7])
		else $error("clear bit 7 of a narrow channel not zero");
	a_unmapped: assert property (rd_ok && avs_address > 5'h1a |-> avs_readdata == 32'h0)
		else $error("unmapped word reads nonzero");

	// Main scenarios that the bench must reach.
	c_clear_a: cover property (counter_run_bit[0] && clk0_q[7:5] == 3'h1 && match_a[0]);
	c_tick_run: cover property (counter_run_bit[0] && count_tick[0]);
	c_mode_read: cover property (rd_ok && avs_address == 5'h01);
endmodule

bind ptu_counter_config ptu_chk ptu_chk_i (.ref_clk, .rst_b, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.match_a, .count_tick, .count_clear, .counter_run_bit);

// file: tb/ptu_ext_pins.sv
`timescale 1ns/1ps

// External count clocks with periods of 16, 32, 64 and 128 reference cycles.
module ptu_ext_pins (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// External count clock pins.
	output logic ext_clock_pin_a,
	output logic ext_clock_pin_b,
	output logic ext_clock_pin_c,
	output logic ext_clock_pin_d
);
	logic [6:0] ph_q;

	// Free phase counter; pins change just after an edge like a synchronous source.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_q <= 7'h00;
		end else begin
			ph_q <= ph_q + 7'h01;
		end
	end

	// Each pin is one phase bit.
	assign ext_clock_pin_a = ph_q[3];
	assign ext_clock_pin_b = ph_q[4];
	assign ext_clock_pin_c = ph_q[5];
	assign ext_clock_pin_d = ph_q[6];
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

module testbench;
	// Source period per channel and code; negative is a pin, zero a cascade.
	localparam int PER [6][8] = '{'{1, 4, 16, 64, -16, -32, -64, -128},
		'{1, 4, 16, 64, -16, -32, 256, 0}, '{1, 4, 16, 64, -16, -32, -64, 1024},
		'{1, 4, 16, 64, -16, 1024, 256, 4096}, '{1, 4, 16, 64, -16, -64, 1024, 0},
		'{1, 4, 16, 64, -16, -64, 256, -128}};
	logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic ext_clock_pin_a, ext_clock_pin_b, ext_clock_pin_c, ext_clock_pin_d;
	logic [5:0] match_a, match_b, match_c, match_d, counter_wrap;
	logic [5:0] count_tick, count_clear, counter_run_bit;
	logic [17:0] op_mode_state;
	logic [23:0] cmp_pin_out, cmp_pin_oe;
	int n_mismatch = 0;
	int total_checks = 0;
	int seed = 32'h91c6a2e9;
	int cnt_t [6];
	int cnt_c [6];
	int ev [6];

	ptu_counter_config ptu_counter_config_i (.ref_clk, .rst_b, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.ext_clock_pin_a, .ext_clock_pin_b, .ext_clock_pin_c, .ext_clock_pin_d,
		.match_a, .match_b, .match_c, .match_d, .counter_wrap, .count_tick, .count_clear,
		.counter_run_bit, .op_mode_state, .cmp_pin_out, .cmp_pin_oe);
	ptu_ext_pins ptu_ext_pins_i (.ref_clk, .rst_b, .ext_clock_pin_a, .ext_clock_pin_b,
		.ext_clock_pin_c, .ext_clock_pin_d);

	// Reference clock at 200 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Cuts a hung run short.
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One bus access, held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] b, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= b;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 40) begin
			n_mismatch++;
			test_done();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'hf, q);
		chk(q, e);
	endtask

	// Called only while the channel is stopped.
	task automatic cfg(input int ch, input logic [7:0] ck, input logic [7:0] md);
		wr(5'(ch * 4), ck);
		wr(5'(ch * 4 + 1), md);
	endtask

	// Counts ticks and clears; optionally sends sparse match and wrap pulses.
	task automatic win(input int cyc, input bit ev_on);
		int i, k;
		logic [31:0] r;
		for (k = 0; k < 6; k++) begin
			cnt_t[k] = 0;
			cnt_c[k] = 0;
			ev[k] = 0;
		end
		for (i = 0; i < cyc + 4; i++) begin
			@(posedge ref_clk);
			r = $random(seed) & {32{ev_on && i < cyc && !i[0]}};
			match_a <= {5'h0, r[0] & r[4]};
			match_b <= {5'h0, r[1] & r[5]};
			match_c <= {5'h0, r[2] & r[6]};
			match_d <= {5'h0, r[3] & r[7]};
			counter_wrap <= {r[8] & r[9], 2'h0, r[10] & r[11], 2'h0};
			for (k = 0; k < 4; k++) ev[k] += r[k] & r[k + 4];
			ev[4] += r[10] & r[11];
			ev[5] += r[8] & r[9];
			@(negedge ref_clk);
			for (k = 0; k < 6; k++) begin
				cnt_t[k] += count_tick[k];
				cnt_c[k] += count_clear[k];
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i, ch, p, k, per, e, x;
		logic [31:0] r;
		logic [7:0] v;
		logic [3:0] c, eo, eoe;
		logic [23:0] all_o;
		logic w;
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		{match_a, match_b, match_c, match_d, counter_wrap} = '0;
		rst_b = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (ch = 0; ch < 6; ch++) begin
			rdc(5'(ch * 4), 32'h00);
			rdc(5'(ch * 4 + 1), 32'hc0);
			rdc(5'(ch * 4 + 2), 32'h00);
			rdc(5'(ch * 4 + 3), 32'h00);
		end
		$display("test reset_values done");
		for (ch = 0; ch < 6; ch++) begin
			r = $random(seed);
			w = (ch == 0 || ch == 3);
			v = {r[15:12], 1'b0, w ? 1'b0 : r[10], r[9:8]};
			wr(5'(ch * 4), r[7:0]);
			rdc(5'(ch * 4), w ? {24'h0, r[7:0]} : {25'h0, r[6:0]});
			wr(5'(ch * 4 + 1), v);
			rdc(5'(ch * 4 + 1), {26'h3, w ? v[5:4] : 2'h0, v[3:0]});
			wr(5'(ch * 4 + 2), r[23:16]);
			rdc(5'(ch * 4 + 2), {24'h0, r[23:16]});
			wr(5'(ch * 4 + 3), r[31:24]);
			rdc(5'(ch * 4 + 3), w ? {24'h0, r[31:24]} : 32'h0);
		end
		wr(5'h00, 8'h00);
		bus(1'b1, 5'h00, 8'h5a, 4'he, r);
		rdc(5'h00, 32'h00);
		wr(5'h1f, 8'hff);
		rdc(5'h1f, 32'h00);
		$display("test register_access done");
		for (ch = 0; ch < 6; ch++) begin
			for (p = 0; p < 8; p++) begin
				per = PER[ch][p];
				if (per == 4096) continue;
				r = $random(seed);
				w = (ch == 0 || ch == 3);
				x = w ? int'(r[9:8]) : int'(r[10:8]);
				x = (x == 1) ? 0 : x;
				cfg(ch, {3'h0, r[1:0], 3'(p)}, 8'(x));
				wr(5'h18, 8'(1 << ch));
				repeat (4) @(posedge ref_clk);
				@(negedge ref_clk);
				chk(32'(op_mode_state[ch * 3 +: 3]), (x == 0) ? 0 : x - 1);
				chk(32'(counter_run_bit), 32'(1 << ch));
				win(1020, per == 0);
				wr(5'h18, 8'h00);
				e = (per == 0) ? ev[ch == 1 ? 4 : 5] : 1024 / (per < 0 ? -per : per);
				if (r[1] && per != 1 && per != 0) e = e * 2;
				if (!w && x >= 4) e = 0;
				chk(32'(cnt_t[ch]), 32'(e));
			end
		end
		$display("test count_sources done");
		for (i = 0; i < 16; i++) begin
			c = 4'(i);
			cfg(0, {c[2:0], 5'h00}, {2'h0, c[3], c[3], 4'h0});
			cfg(3, {c[0], 2'h3, 5'h00}, 8'h00);
			wr(5'h19, 8'h09);
			wr(5'h18, 8'h09);
			repeat (4) @(posedge ref_clk);
			win(300, 1'b1);
			wr(5'h18, 8'h00);
			case (c[2:0])
				3'h1: e = ev[0];
				3'h2: e = ev[1];
				3'h5: e = c[3] ? 0 : ev[2];
				3'h6: e = c[3] ? 0 : ev[3];
				default: e = 0;
			endcase
			chk(32'(cnt_c[0]), 32'(e));
			chk(32'(cnt_c[3]), 32'(e));
		end
		$display("test clear_sources done");
		all_o = 24'h0;
		for (i = 0; i < 12; i++) begin
			ch = i % 6;
			r = $random(seed);
			w = (ch == 0 || ch == 3);
			cfg(ch, 8'h00, {2'h0, r[17:16], 4'h0});
			wr(5'(ch * 4 + 2), r[7:0]);
			wr(5'(ch * 4 + 3), r[15:8]);
			repeat (2) @(negedge ref_clk);
			for (k = 0; k < 4; k++) begin
				c = r[k * 4 +: 4];
				eoe[k] = !c[3] && c[1:0] != 2'h0 && (w || k < 2) && !(k >= 2 && r[14 + k]);
				eo[k] = eoe[k] && c[2];
			end
			chk(32'(cmp_pin_oe[ch * 4 +: 4]), 32'(eoe));
			chk(32'(cmp_pin_out[ch * 4 +: 4]), 32'(eo));
			all_o[ch * 4 +: 4] = eo;
		end
		rdc(5'h1a, {8'h0, all_o});
		$display("test initial_levels done");
		cfg(0, 8'h00, 8'h00);
		wr(5'h02, 8'h03);
		wr(5'h18, 8'h01);
		for (i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			match_a <= 6'h01;
			@(posedge ref_clk);
			match_a <= 6'h00;
			repeat (2) @(negedge ref_clk);
			chk(32'(cmp_pin_out[0]), 32'(!i[0]));
		end
		wr(5'h18, 8'h00);
		repeat (2) @(negedge ref_clk);
		chk(32'(cmp_pin_out[0]), 32'h0);
		$display("test toggle_output done");
		test_done();
	end
endmodule
